// ### design/bcacc_pkg.sv
package bcacc_pkg;

  // ----------------------------------------------------------------
  // Widths and units
  // ----------------------------------------------------------------
  // Sense LSB is 10 uV, temperature LSB is 1 degree C (signed)
  localparam int SENSE_W = 16;
  localparam int MAG_W   = 15;
  localparam int CAP_W   = 16;
  localparam int PCT_W   = 7;
  localparam int RES_W   = 11;
  localparam int AMT_W   = 22;
  localparam int SD_W    = 48;

  // ----------------------------------------------------------------
  // Thresholds
  // ----------------------------------------------------------------
  localparam logic [MAG_W-1:0] FILTER_THRESH = 15'h0028;
  localparam logic [MAG_W-1:0] DEAD_BAND     = 15'h001E;
  localparam logic [MAG_W-1:0] DISP_THRESH   = 15'h00C8;
  localparam logic [MAG_W-1:0] MAG_MAX       = 15'h7FFF;
  // Sense magnitude equal to learned capacity divided by this is 1C
  localparam logic [7:0]       C_RATE_SCALE  = 8'h08;
  // Sense-percent products per capacity count
  localparam logic [AMT_W-1:0] CNT_DIV       = 22'h000640;
  localparam logic [CAP_W-1:0] CAP_MAX       = 16'hFFFF;

  localparam logic signed [7:0] T_CHG_HOT  = 8'sh28;
  localparam logic signed [7:0] T_SD_BAND  = 8'sh1E;
  localparam logic signed [7:0] T_COLD     = 8'sh0A;
  localparam logic signed [7:0] T_ZERO     = 8'sh00;
  localparam logic signed [7:0] T_M10      = -8'sh0A;
  localparam logic signed [7:0] T_M20      = -8'sh14;
  localparam logic [7:0]        T_STEP     = 8'h0A;

  // ----------------------------------------------------------------
  // Factors in percent and C-rate ratios
  // ----------------------------------------------------------------
  localparam logic [PCT_W-1:0] PCT_100 = 7'h64;
  localparam logic [PCT_W-1:0] PCT_95  = 7'h5F;
  localparam logic [PCT_W-1:0] PCT_90  = 7'h5A;
  localparam logic [PCT_W-1:0] PCT_85  = 7'h55;
  localparam logic [PCT_W-1:0] PCT_80  = 7'h50;
  localparam logic [PCT_W-1:0] PCT_75  = 7'h4B;
  localparam logic [PCT_W-1:0] PCT_50  = 7'h32;
  localparam logic [PCT_W-1:0] PCT_40  = 7'h28;
  localparam logic [PCT_W-1:0] PCT_0   = 7'h00;
  localparam logic [PCT_W-1:0] PCT_STEP = 7'h05;
  localparam logic [3:0] RATE_FAST_DEN = 4'h5;
  localparam logic [3:0] RATE_6C       = 4'h6;
  localparam logic [3:0] RATE_12C      = 4'hC;
  localparam logic [3:0] ONE           = 4'h1;

  // ----------------------------------------------------------------
  // Self-discharge timing and stale counter
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ     = 10_000_000;
  localparam longint unsigned SD_DAY_S   = 86_400;
  localparam longint unsigned SD_DAY_CYC = SD_DAY_S * CLK_HZ;
  localparam logic [CAP_W-1:0] SD_DIV_NICD = 16'h0050;
  localparam logic [CAP_W-1:0] SD_DIV_NIMH = 16'h003C;
  localparam logic [7:0] STALE_MAX   = 8'hFF;
  localparam logic [7:0] STALE_LIMIT = 8'h40;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_IDLE  = 3'b001,
    MODE_DISCH = 3'b010,
    MODE_CHG   = 3'b100
  } bcacc_mode_t;

  typedef struct packed {
    logic                      valid;
    logic signed [SENSE_W-1:0] volt;
  } bcacc_sense_t;

  typedef struct packed {
    logic [CAP_W-1:0] remaining;
    logic [CAP_W-1:0] tally;
    logic [CAP_W-1:0] full;
    logic [7:0]       stale_count;
    logic             stale_flag;
    logic [PCT_W-1:0] display_pct;
    logic             display_on;
    logic             charging;
    logic             discharging;
  } bcacc_status_t;

  // Full reference per select level; upper eight levels are NiMH
  function automatic logic [CAP_W-1:0] pfc_count(input logic [3:0] lvl);
    case (lvl)
      4'h0: pfc_count = 16'h7800;
      4'h1: pfc_count = 16'h6300;
      4'h2: pfc_count = 16'hA200;
      4'h3: pfc_count = 16'h8400;
      4'h4: pfc_count = 16'h6C00;
      4'h5: pfc_count = 16'hB400;
      4'h6: pfc_count = 16'h9000;
      4'h7: pfc_count = 16'h7800;
      4'h8: pfc_count = 16'h9C00;
      4'h9: pfc_count = 16'hB400;
      4'hA: pfc_count = 16'h6C00;
      4'hB: pfc_count = 16'h8400;
      4'hC: pfc_count = 16'h9C00;
      4'hD: pfc_count = 16'hBA00;
      4'hE: pfc_count = 16'h6F00;
      default: pfc_count = 16'h8400;
    endcase
  endfunction

  // True when sense rate exceeds num/den C of the learned capacity
  function automatic logic rate_above(input logic [MAG_W-1:0] mag,
                                      input logic [CAP_W-1:0] learned_full_capacity,
                                      input logic [3:0] num,
                                      input logic [3:0] den);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = 32'(mag) * 32'(C_RATE_SCALE) * 32'(den);
    rhs = 32'(learned_full_capacity) * 32'(num);
    rate_above = lhs > rhs;
  endfunction

endpackage

// ### design/bcacc_comp.sv
`timescale 1ns/100ps
// Rate and temperature efficiency selection for one sense sample
module bcacc_comp
  import bcacc_pkg::*;
(
  // Sample
  input  wire logic [MAG_W-1:0] mag_in,
  input  wire logic             charging_in,
  // Conditions
  input  wire logic [CAP_W-1:0] lmd_in,
  input  wire logic signed [7:0] temp_in,
  input  wire logic             nimh_in,
  // Result
  output logic [PCT_W-1:0]      eff_out
);

  logic             fast;
  logic             hot;
  logic [PCT_W-1:0] chg_eff;
  logic [PCT_W-1:0] dis_base;
  logic [7:0]       steps;
  logic [7:0]       cut;

  always_comb
  begin
    fast = rate_above(mag_in, lmd_in, ONE, RATE_FAST_DEN);
    hot  = temp_in >= T_CHG_HOT;
    case ({nimh_in, hot, fast})
      3'b000:  chg_eff = PCT_80;
      3'b001:  chg_eff = PCT_95;
      3'b010:  chg_eff = PCT_75;
      3'b011:  chg_eff = PCT_90;
      3'b100:  chg_eff = PCT_80;
      3'b101:  chg_eff = PCT_90;
      3'b110:  chg_eff = PCT_75;
      default: chg_eff = PCT_85;
    endcase
    if (rate_above(mag_in, lmd_in, RATE_12C, ONE))
      dis_base = PCT_90;
    else if (rate_above(mag_in, lmd_in, RATE_6C, ONE))
      dis_base = PCT_95;
    else
      dis_base = PCT_100;
    if (temp_in < T_COLD)
      steps = 8'((8'(T_COLD) - 8'(temp_in) + T_STEP - 8'h01) / T_STEP);
    else
      steps = 8'h00;
    cut = 8'(steps * 8'(PCT_STEP));
    if (charging_in)
      eff_out = chg_eff;
    else if (cut >= 8'(dis_base))
      eff_out = PCT_0;
    else
      eff_out = PCT_W'(8'(dis_base) - cut);
  end

endmodule

// ### design/bcacc_core.sv
`timescale 1ns/100ps
// Function
// - Count discharge below negative filter threshold
// - Display on while discharge below -2 mV
// - Discharge ends above negative dead band
// - Scale discharge by rate and temperature
// - Self-discharge 1/80 NiCd, 1/60 NiMH daily
// - Self-discharge doubles per 10 C rise above 30 C
// - Charge above C/5 is quick
// - NiCd charge efficiency by rate, temperature
// - NiMH charge efficiency by rate, temperature
// - Discharge efficiency 100/95/90 by C rate
// - C rate uses learned full capacity
// - Minus 5 percent per step below 10 C
// - Stale counter counts charges, clears on learn
// - Stale counter saturates at 255
// - Stale flag after 64 charges unlearned
// - Display is remaining over learned full
// - Display scaling leaves remaining count untouched
// - NiCd display scaling by temperature bands
// - NiMH display scaling by temperature bands
// - Charge counts up until below dead band
module bcacc_core
  import bcacc_pkg::*;
#(
  parameter longint unsigned SD_PERIOD_CYC = SD_DAY_CYC
)
(
  // Clock and reset
  input  wire logic           CLK_IN,
  input  wire logic           RESET_IN,
  // Front end samples, same clock
  input  wire bcacc_sense_t   SENSE_IN,
  input  wire logic signed [7:0] TEMP_IN,
  input  wire logic [3:0]     FULL_REF_SEL_IN,
  // Learning events
  input  wire logic           VALID_CHARGE_IN,
  input  wire logic           LEARN_IN,
  // Status
  output bcacc_status_t       STATUS_OUT
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [CAP_W-1:0] sat_sub(input logic [CAP_W-1:0] a,
                                               input logic [CAP_W-1:0] b);
    sat_sub = (b > a) ? '0 : CAP_W'(a - b);
  endfunction

  function automatic logic [CAP_W-1:0] sat_add(input logic [CAP_W-1:0] a,
                                               input logic [CAP_W-1:0] b,
                                               input logic [CAP_W-1:0] lim);
    logic [CAP_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s > {1'b0, lim}) ? lim : CAP_W'(s);
  endfunction

  // Temperature translation of the display
  function automatic logic [PCT_W-1:0] disp_trans(input logic nimh,
                                                  input logic signed [7:0] t);
    if (!nimh)
    begin
      if (t >= T_ZERO)
        disp_trans = PCT_100;
      else if (t >= T_M10)
        disp_trans = PCT_90;
      else if (t >= T_M20)
        disp_trans = PCT_75;
      else
        disp_trans = PCT_50;
    end
    else
    begin
      if (t >= T_COLD)
        disp_trans = PCT_100;
      else if (t >= T_ZERO)
        disp_trans = PCT_75;
      else if (t >= T_M10)
        disp_trans = PCT_40;
      else
        disp_trans = PCT_0;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bcacc_mode_t      mode_reg,  mode_next;
  logic [CAP_W-1:0] nac_reg,   nac_next;
  logic [CAP_W-1:0] dcr_reg,   dcr_next;
  logic [CAP_W-1:0] lmd_reg,   lmd_next;
  logic [RES_W-1:0] res_reg,   res_next;
  logic [SD_W-1:0]  sd_reg,    sd_next;
  logic [7:0]       cpi_reg,   cpi_next;
  logic             ci_reg,    ci_next;
  logic             init_reg,  init_next;
  logic             nimh_reg,  nimh_next;
  logic             disp_reg,  disp_next;
  bcacc_status_t    status_reg, status_next;

  // ----------------------------------------------------------------
  // Sample decode
  // ----------------------------------------------------------------
  logic             neg;
  logic [MAG_W-1:0] mag;
  logic [PCT_W-1:0] eff;
  logic [AMT_W-1:0] sum;
  logic [CAP_W-1:0] units;
  logic [CAP_W-1:0] sd_drop;
  logic [SD_W-1:0]  sd_inc;
  logic [3:0]       sd_dbl;
  logic [7:0]       t_over;
  logic [31:0]      pct_raw;
  logic [PCT_W-1:0] pct_full;
  logic [13:0]      pct_scaled;

  always_comb
  begin
    neg = SENSE_IN.volt[SENSE_W-1];
    if (SENSE_IN.volt == 16'sh8000)
      mag = MAG_MAX;
    else if (neg)
      mag = MAG_W'(-SENSE_IN.volt);
    else
      mag = MAG_W'(SENSE_IN.volt);
  end

  // Charge flag steers the factor choice for this very sample
  bcacc_comp u_comp (
    .mag_in      (mag),
    .charging_in (!neg),
    .lmd_in      (lmd_reg),
    .temp_in     (TEMP_IN),
    .nimh_in     (nimh_reg),
    .eff_out     (eff)
  );

  // ----------------------------------------------------------------
  // Counting and learning
  // ----------------------------------------------------------------
  always_comb
  begin
    mode_next = mode_reg;
    nac_next  = nac_reg;
    dcr_next  = dcr_reg;
    lmd_next  = lmd_reg;
    res_next  = res_reg;
    sd_next   = sd_reg;
    cpi_next  = cpi_reg;
    ci_next   = ci_reg;
    nimh_next = nimh_reg;
    disp_next = disp_reg;
    init_next = 1'b0;
    units     = '0;
    sum       = '0;
    sd_drop   = '0;
    t_over    = 8'h00;
    sd_dbl    = 4'h0;
    sd_inc    = '0;
    // Strap levels are taken on the first edge after reset release
    if (init_reg)
    begin
      lmd_next  = pfc_count(FULL_REF_SEL_IN);
      nimh_next = FULL_REF_SEL_IN[3];
    end
    else
    begin
      if (SENSE_IN.valid)
      begin
        case (mode_reg)
          MODE_IDLE:
          begin
            if (neg && mag > FILTER_THRESH)
              mode_next = MODE_DISCH;
            else if (!neg && mag > FILTER_THRESH)
              mode_next = MODE_CHG;
          end
          MODE_DISCH:
          begin
            if (!neg || mag < DEAD_BAND)
              mode_next = MODE_IDLE;
          end
          MODE_CHG:
          begin
            if (neg || mag < DEAD_BAND)
              mode_next = MODE_IDLE;
          end
          default:
            mode_next = MODE_IDLE;
        endcase
        sum = AMT_W'(res_reg) + AMT_W'(mag) * AMT_W'(eff);
        if (mode_next != MODE_IDLE)
        begin
          units    = CAP_W'(sum / CNT_DIV);
          res_next = RES_W'(sum % CNT_DIV);
        end
        disp_next = (mode_next == MODE_DISCH && neg && mag > DISP_THRESH)
                 || (mode_next == MODE_CHG && !neg && mag > DISP_THRESH);
      end
      if (mode_next == MODE_DISCH)
      begin
        nac_next = sat_sub(nac_reg, units);
        dcr_next = sat_add(dcr_reg, units, CAP_MAX);
      end
      // Charge never lifts remaining past the learned full value
      else if (mode_next == MODE_CHG)
        nac_next = sat_add(nac_reg, units, lmd_reg);
      if (mode_next == MODE_IDLE)
        disp_next = 1'b0;

      // doubling per 10 C above band
      if (TEMP_IN > T_SD_BAND)
        t_over = 8'((8'(TEMP_IN) - 8'(T_SD_BAND) - 8'h01) / T_STEP + 8'h01);
      else
        t_over = 8'h00;
      sd_dbl = (t_over > 8'h0F) ? 4'hF : t_over[3:0];
      sd_inc = SD_W'(1) << sd_dbl;
      if (sd_reg + sd_inc >= SD_W'(SD_PERIOD_CYC))
      begin
        sd_next = SD_W'(sd_reg + sd_inc - SD_W'(SD_PERIOD_CYC));
        sd_drop = nimh_reg ? nac_next / SD_DIV_NIMH : nac_next / SD_DIV_NICD;
        nac_next = sat_sub(nac_next, sd_drop);
        dcr_next = sat_add(dcr_next, sd_drop, CAP_MAX);
      end
      else
        sd_next = SD_W'(sd_reg + sd_inc);

      if (LEARN_IN)
      begin
        lmd_next = dcr_reg;
        cpi_next = '0;
      end
      if (VALID_CHARGE_IN && cpi_next != STALE_MAX)
        cpi_next = cpi_next + 8'h01;
      if (cpi_next >= STALE_LIMIT)
        ci_next = 1'b1;
      else if (LEARN_IN)
        ci_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Display
  // ----------------------------------------------------------------
  always_comb
  begin
    if (lmd_reg == '0)
      pct_raw = '0;
    else
      pct_raw = (32'(nac_reg) * 32'(PCT_100)) / 32'(lmd_reg);
    pct_full = (pct_raw > 32'(PCT_100)) ? PCT_100 : PCT_W'(pct_raw);
    pct_scaled = 14'(pct_full) * 14'(disp_trans(nimh_reg, TEMP_IN));
    status_next.remaining   = nac_next;
    status_next.tally       = dcr_next;
    status_next.full        = lmd_next;
    status_next.stale_count = cpi_next;
    status_next.stale_flag  = ci_next;
    status_next.display_pct = PCT_W'(pct_scaled / 14'(PCT_100));
    status_next.display_on  = disp_next;
    status_next.charging    = mode_next == MODE_CHG;
    status_next.discharging = mode_next == MODE_DISCH;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RESET_IN)
  begin
    if (RESET_IN)
    begin
      mode_reg   <= MODE_IDLE;
      nac_reg    <= '0;
      dcr_reg    <= '0;
      lmd_reg    <= '0;
      res_reg    <= '0;
      sd_reg     <= '0;
      cpi_reg    <= '0;
      ci_reg     <= 1'b1;
      init_reg   <= 1'b1;
      nimh_reg   <= 1'b0;
      disp_reg   <= 1'b0;
      status_reg <= '{stale_flag: 1'b1, default: '0};
    end
    else
    begin
      mode_reg   <= mode_next;
      nac_reg    <= nac_next;
      dcr_reg    <= dcr_next;
      lmd_reg    <= lmd_next;
      res_reg    <= res_next;
      sd_reg     <= sd_next;
      cpi_reg    <= cpi_next;
      ci_reg     <= ci_next;
      init_reg   <= init_next;
      nimh_reg   <= nimh_next;
      disp_reg   <= disp_next;
      status_reg <= status_next;
    end
  end

  assign STATUS_OUT = status_reg;

endmodule

// ### tb/bcacc_cells.sv
`timescale 1ns/100ps
// Cells behind the sense resistor: one front end sample per request
module bcacc_cells
  import bcacc_pkg::*;
(
  // Requests from the bench
  input  wire logic               clk_in,
  input  wire logic               go_in,
  input  wire logic signed [15:0] volt_in,
  input  wire logic signed [7:0]  temp_in,
  // Front end outputs
  output bcacc_sense_t            sense_out,
  output logic signed [7:0]       temp_out
);
  logic signed [15:0] last_reg = 16'h5A5A;

  // Between samples the value toggles so a stale read cannot pass
  always_ff @(posedge clk_in)
    last_reg <= go_in ? volt_in : ~last_reg;
  assign sense_out = {go_in, go_in ? volt_in : ~last_reg};
  assign temp_out  = temp_in;
endmodule

// ### tb/bcacc_core_monitor.sv
`timescale 1ns/100ps
module bcacc_core_monitor
  import bcacc_pkg::*;
#(
  parameter longint unsigned SD_PERIOD_CYC = SD_DAY_CYC
)
(
  // Clock and reset
  input wire logic              CLK_IN,
  input wire logic              RESET_IN,
  // Watched ports
  input wire bcacc_sense_t      SENSE_IN,
  input wire logic signed [7:0] TEMP_IN,
  input wire logic [3:0]        FULL_REF_SEL_IN,
  input wire logic              VALID_CHARGE_IN,
  input wire logic              LEARN_IN,
  input wire bcacc_status_t     STATUS_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic live_reg;

  // Inputs are ignored on the first edge after reset
  always_ff @(posedge CLK_IN or posedge RESET_IN)
    if (RESET_IN) live_reg <= 1'b0;
    else live_reg <= 1'b1;

  property p_disch_count;
    live_reg && SENSE_IN.valid && SENSE_IN.volt <= -16'sd1600 && !STATUS_OUT.charging
      && TEMP_IN > -8'sd50 && STATUS_OUT.tally < CAP_MAX
      |=> STATUS_OUT.discharging && STATUS_OUT.tally > $past(STATUS_OUT.tally);
  endproperty
  a_disch_count: assert property (p_disch_count) else $error("discharge not counted");
  property p_disp;
    live_reg && SENSE_IN.valid && SENSE_IN.volt < -16'sd200 && !STATUS_OUT.charging
      |=> STATUS_OUT.display_on && STATUS_OUT.discharging;
  endproperty
  a_disp: assert property (p_disp) else $error("display not on in discharge");
  property p_disch_end;
    live_reg && SENSE_IN.valid && STATUS_OUT.discharging && SENSE_IN.volt > -16'sd30
      |=> !STATUS_OUT.discharging;
  endproperty
  a_disch_end: assert property (p_disch_end) else $error("discharge did not end");
  property p_chg_count;
    live_reg && SENSE_IN.valid && STATUS_OUT.charging && SENSE_IN.volt > 16'sd40
      |=> STATUS_OUT.charging && (STATUS_OUT.remaining >= $past(STATUS_OUT.remaining)
      || STATUS_OUT.tally != $past(STATUS_OUT.tally));
  endproperty
  a_chg_count: assert property (p_chg_count) else $error("charge not counted");
  property p_rise_chg;
    live_reg && STATUS_OUT.remaining > $past(STATUS_OUT.remaining) |-> STATUS_OUT.charging;
  endproperty
  a_rise_chg: assert property (p_rise_chg) else $error("remaining rose outside charge");
  property p_tally_mono;
    live_reg |-> STATUS_OUT.tally >= $past(STATUS_OUT.tally);
  endproperty
  a_tally_mono: assert property (p_tally_mono) else $error("tally went down");
  property p_stale_clr;
    live_reg && LEARN_IN && !VALID_CHARGE_IN |=> STATUS_OUT.stale_count == 8'h00;
  endproperty
  a_stale_clr: assert property (p_stale_clr) else $error("stale count not cleared");
  property p_stale_inc;
    live_reg && VALID_CHARGE_IN && !LEARN_IN && STATUS_OUT.stale_count != STALE_MAX
      |=> STATUS_OUT.stale_count == $past(STATUS_OUT.stale_count) + 8'h01;
  endproperty
  a_stale_inc: assert property (p_stale_inc) else $error("stale count not raised");
  property p_stale_sat;
    live_reg && STATUS_OUT.stale_count == STALE_MAX && !LEARN_IN
      |=> STATUS_OUT.stale_count == STALE_MAX;
  endproperty
  a_stale_sat: assert property (p_stale_sat) else $error("stale count wrapped");
  property p_stale_flag;
    (STATUS_OUT.stale_count >= STALE_LIMIT) [*2] |-> STATUS_OUT.stale_flag;
  endproperty
  a_stale_flag: assert property (p_stale_flag) else $error("stale flag missing");
  property p_nimh_cold;
    (FULL_REF_SEL_IN[3] && TEMP_IN < T_M10) [*3] |-> STATUS_OUT.display_pct == PCT_0;
  endproperty
  a_nimh_cold: assert property (p_nimh_cold) else $error("cold display not zero");
endmodule

bind bcacc_core bcacc_core_monitor #(.SD_PERIOD_CYC(SD_PERIOD_CYC)) u_monitor (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .SENSE_IN(SENSE_IN), .TEMP_IN(TEMP_IN),
  .FULL_REF_SEL_IN(FULL_REF_SEL_IN), .VALID_CHARGE_IN(VALID_CHARGE_IN),
  .LEARN_IN(LEARN_IN), .STATUS_OUT(STATUS_OUT)
);

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
  import bcacc_pkg::*;
  // ------
  // Set-up
  // ------
  localparam longint unsigned SD = 64'd4000;
  localparam int PROGRAMMED_FULL_REFERENCE[16] = '{30720, 25344, 41472, 33792, 27648, 46080, 36864, 30720,
                             39936, 46080, 27648, 33792, 39936, 47616, 28416, 33792};
  localparam int TMP[9] = '{25, 10, 5, 0, -5, -10, -15, -20, -25};
  localparam int CV[16] = '{-40, -41, -31, -30, -29, 0, 41, 40, 30, 29, 201, 200,
                            -201, -200, -41, 16000};
  localparam int SS[3] = '{0, 8, 0};
  localparam int ST[3] = '{25, 40, 60};
  localparam int SV[3] = '{80, 60, 80};
  localparam int SM[3] = '{1, 2, 8};
  logic               clk, rst, vchg, learn, go;
  logic [3:0]         sel;
  logic signed [15:0] cmd_v;
  logic signed [7:0]  cmd_t, temp;
  bcacc_sense_t       sense;
  bcacc_status_t      st;
  logic [31:0]        lfsr;
  bit                 nm;
  int n_mismatch, total_checks, cyc, er, et, ef, res, md, sc;

  bcacc_cells u_cells (.clk_in(clk), .go_in(go), .volt_in(cmd_v), .temp_in(cmd_t),
                       .sense_out(sense), .temp_out(temp));
  bcacc_core #(.SD_PERIOD_CYC(SD)) dut (.CLK_IN(clk), .RESET_IN(rst), .SENSE_IN(sense),
    .TEMP_IN(temp), .FULL_REF_SEL_IN(sel), .VALID_CHARGE_IN(vchg), .LEARN_IN(learn),
    .STATUS_OUT(st));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;

  // ------
  // Reference and drivers
  // ------
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int eff(input int v);
    int m, e, t;
    m = v < 0 ? -v : v;
    t = cmd_t;
    if (v > 0)
      e = (nm ? (m * 40 > ef ? 90 : 80) : (m * 40 > ef ? 95 : 80)) - (t >= 40 ? 5 : 0);
    else
    begin
      e = m * 8 > 12 * ef ? 90 : (m * 8 > 6 * ef ? 95 : 100);
      if (t < 10) e -= 5 * ((19 - t) / 10);
    end
    return e < 0 ? 0 : e;
  endfunction
  function automatic int pct();
    int p, t, k;
    t = cmd_t;
    p = er * 100 / ef;
    if (p > 100) p = 100;
    if (nm) k = t >= 10 ? 100 : t >= 0 ? 75 : t >= -10 ? 40 : 0;
    else k = t >= 0 ? 100 : t >= -10 ? 90 : t >= -20 ? 75 : 50;
    return p * k / 100;
  endfunction
  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm_s, input logic [31:0] got, input int exp);
    total_checks++;
    if (got !== 32'(exp))
    begin
      $display("CHECK FAILED %s expected %0d seen %0d", nm_s, exp, got);
      n_mismatch++;
    end
  endtask
  task automatic upto(input int c);
    for (int k = 0; k < 5000 && cyc < c; k++) @(negedge clk);
    if (cyc < c)
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic rst_to(input logic [3:0] s, input int t);
    @(negedge clk);
    rst = 1'b1;
    sel = s;
    cmd_t = 8'(t);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    {er, et, res, md, sc} = '0;
    ef = PROGRAMMED_FULL_REFERENCE[s];
    nm = s[3];
    @(negedge clk);
    chk("full", st.full, ef);
    chk("stale_flag", st.stale_flag, 1);
  endtask
  task automatic quiet();
    go = 1'b0;
    {vchg, learn} = 2'b00;
    @(negedge clk);
  endtask
  task automatic sample(input int v);
    int m, s, u;
    m = v < 0 ? -v : v;
    cmd_v = 16'(v);
    {vchg, learn} = 2'b00;
    go = 1'b1;
    @(negedge clk);
    case (md)
      0: md = v < -40 ? 1 : (v > 40 ? 2 : 0);
      1: if (v >= 0 || m < 30) md = 0;
      default: if (v <= 0 || m < 30) md = 0;
    endcase
    if (md != 0)
    begin
      s = res + m * eff(v);
      u = s / 1600;
      res = s % 1600;
      if (md == 1)
      begin
        er = er > u ? er - u : 0;
        et = et + u > 65535 ? 65535 : et + u;
      end
      else
        er = er + u > ef ? ef : er + u;
    end
    chk("remaining", st.remaining, er);
    chk("tally", st.tally, et);
    chk("discharging", st.discharging, md == 1);
    chk("charging", st.charging, md == 2);
    if (md == 0 || m > 200) chk("display_on", st.display_on, md != 0);
  endtask
  task automatic ev(input logic vc, input logic ln);
    vchg = vc;
    learn = ln;
    @(negedge clk);
    if (ln)
    begin
      sc = 0;
      ef = et;
    end
    if (vc && sc < 255) sc++;
    chk("stale_count", st.stale_count, sc);
    chk("full", st.full, ef);
  endtask

  initial
  begin
    n_mismatch = 0;
    total_checks = 0;
    lfsr = 32'h532D;
    {rst, go, vchg, learn, sel, cmd_v, cmd_t} = {1'b1, 31'h0};
    // Both chemistries: charge rates, discharge rates, cold, display bands
    for (int c = 0; c < 2; c++)
    begin
      rst_to(c ? 4'h8 : 4'h0, 25);
      repeat (10) sample(16000);
      repeat (3) sample(500);
      cmd_t = 8'h2D;
      repeat (3) sample(16000);
      repeat (3) sample(500);
      cmd_t = 8'h19;
      sample(0);
      sample(-1000);
      sample(-25000);
      cmd_t = -8'sh0F;
      sample(-20000);
      cmd_t = 8'h05;
      sample(-5000);
      sample(-29);
      quiet();
      foreach (TMP[i])
      begin
        cmd_t = 8'(TMP[i]);
        repeat (3) @(negedge clk);
        chk("display_pct", st.display_pct, pct());
        chk("remaining", st.remaining, er);
      end
    end
    // Thresholds, then random traffic
    rst_to(4'h0, 0);
    foreach (CV[i]) sample(CV[i]);
    repeat (150)
    begin
      lfsr = nx(lfsr);
      cmd_t = 8'(int'(lfsr[15:8] % 8'd61) - 30);
      sample(int'(lfsr[31:16] % 16'd40001) - 20000);
    end
    // Learned capacity drives the C rate; stale counting
    rst_to(4'h0, 25);
    repeat (5) sample(-30000);
    sample(0);
    quiet();
    ev(1'b0, 1'b1);
    sample(-16000);
    sample(-(3 * ef) / 2);
    sample(-(3 * ef) / 4);
    sample(0);
    quiet();
    repeat (63) ev(1'b1, 1'b0);
    ev(1'b0, 1'b0);
    chk("stale_flag", st.stale_flag, 0);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b0);
    chk("stale_flag", st.stale_flag, 1);
    repeat (200) ev(1'b1, 1'b0);
    ev(1'b1, 1'b1);
    ev(1'b0, 1'b0);
    // Self-discharge period and its temperature doubling
    for (int i = 0; i < 3; i++)
    begin
      rst_to(4'(SS[i]), ST[i]);
      repeat (8) sample(16000);
      sample(0);
      quiet();
      upto(4000 / SM[i] - 8);
      chk("remaining", st.remaining, er);
      upto(4000 / SM[i] + 8);
      et += er / SV[i];
      er -= er / SV[i];
      chk("remaining", st.remaining, er);
      chk("tally", st.tally, et);
    end
    report_and_stop();
  end
endmodule
